// >>> rtl/byte_ports.sv
// general byte port with per-line direction, auxiliary port and handshake engine
`timescale 1ns/1ps
`default_nettype none
`include "byte_ports_defines.svh"
module byte_ports (
    input wire logic clock,
    input wire logic sys_rst,
    input wire byte_ports_pkg::reg_req_type regReq,
    output logic [7:0] regRdata,
    input wire logic [7:0] generalPortIn,
    output logic [7:0] generalPortOut,
    output logic [7:0] generalPortOe,
    input wire logic [3:0] auxPortIn,
    output logic [3:0] auxPortOut,
    output logic [3:0] intRequest,
    output logic hsIntRequest
);
    ////////////////////////////////////////////////////////////////////////
    // pin sampling
    logic [7:0] gpMeta_q, gpSync_q;
    logic [3:0] auxMeta_q, auxSync_q;
    logic [7:0] dirReg_q, dirReg_d;
    logic [7:0] funcReg_q, funcReg_d;
    logic [7:0] outReg_q, outReg_d;
    logic [3:0] auxOut_q, auxOut_d;
    logic [7:0] inReg_q, inReg_d;
    logic [7:0] rdata_d;
    logic strobePrev_q, readyPrev_q;
    logic hsEnable, hsInput, strobeIn, readyIn, hsLineOut_q, hsLineOut_d;
    logic gpRead, gpWrite;
    logic [7:0] hsMask;
    byte_ports_pkg::hs_state_type state_q, state_d;
    logic fifoValid, fifoReady, fifoOutValid, fifoPop;
    logic [7:0] fifoData;
    logic intPulse_d;
    // two stages settle asynchronous pins before a read sees them
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gpMeta_q <= 8'h00;
            gpSync_q <= 8'h00;
            // idle-high strobe/ready line, so no false edge right after reset
            auxMeta_q <= 4'hf;
            auxSync_q <= 4'hf;
        end else begin
            gpMeta_q <= generalPortIn;
            gpSync_q <= gpMeta_q;
            auxMeta_q <= auxPortIn;
            auxSync_q <= auxMeta_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // handshake decode
    assign hsEnable = funcReg_q[`FUNC_HANDSHAKE_BIT];
    assign hsInput = dirReg_q[`MSB_LINE];
    assign hsMask = hsEnable ? ~(dirReg_q ^ {8{hsInput}}) : 8'h00;
    assign strobeIn = auxSync_q[`HS_LINE_IN];
    assign readyIn = auxSync_q[`HS_LINE_IN];
    assign gpRead = regReq.read && (regReq.addr == `GENERAL_PORT_DATA_ADDR);
    assign gpWrite = regReq.write && (regReq.addr == `GENERAL_PORT_DATA_ADDR);
    assign intRequest = {auxSync_q[0], auxSync_q[1], auxSync_q[3], auxSync_q[2]};
    // output writes queue so up to 8 back-to-back writes during a transfer are not dropped; a write while the fifo is full is lost
    assign fifoValid = gpWrite && hsEnable && !hsInput;
    byte_ports_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) dataFifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .inValid(fifoValid),
        .inReady(fifoReady),
        .inData(regReq.wdata),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );
    ////////////////////////////////////////////////////////////////////////
    // handshake engine
    always_comb begin
        state_d = state_q;
        inReg_d = inReg_q;
        hsLineOut_d = hsLineOut_q;
        intPulse_d = 1'b0;
        fifoPop = 1'b0;
        outReg_d = outReg_q;
        if (gpWrite && !(hsEnable && !hsInput)) begin
            outReg_d = regReq.wdata;
        end
        if (!hsEnable) begin
            state_d = byte_ports_pkg::HS_IDLE;
            hsLineOut_d = 1'b1;
        end else if (hsInput) begin
            case (state_q)
                byte_ports_pkg::HS_IDLE: begin
                    hsLineOut_d = 1'b1;
                    if (strobePrev_q && !strobeIn) begin
                        inReg_d = gpSync_q;
                        intPulse_d = 1'b1;
                        hsLineOut_d = 1'b0;
                        state_d = byte_ports_pkg::HS_BUSY;
                    end
                end
                default: begin
                    hsLineOut_d = 1'b0;
                    if (gpRead) begin
                        state_d = byte_ports_pkg::HS_WAIT;
                    end
                    if ((gpRead || state_q == byte_ports_pkg::HS_WAIT) && strobeIn) begin
                        hsLineOut_d = 1'b1;
                        state_d = byte_ports_pkg::HS_IDLE;
                    end
                end
            endcase
        end else begin
            case (state_q)
                byte_ports_pkg::HS_IDLE: begin
                    hsLineOut_d = 1'b1;
                    if (fifoOutValid && readyIn) begin
                        outReg_d = fifoData;
                        fifoPop = 1'b1;
                        hsLineOut_d = 1'b0;
                        state_d = byte_ports_pkg::HS_BUSY;
                    end
                end
                byte_ports_pkg::HS_BUSY: begin
                    if (readyPrev_q && !readyIn) begin
                        intPulse_d = 1'b1;
                        hsLineOut_d = 1'b1;
                        state_d = byte_ports_pkg::HS_WAIT;
                    end
                end
                default: begin
                    // next data stays queued until ready is back high
                    if (readyIn) begin
                        state_d = byte_ports_pkg::HS_IDLE;
                    end
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_comb begin
        dirReg_d = dirReg_q;
        funcReg_d = funcReg_q;
        auxOut_d = auxOut_q;
        if (regReq.write) begin
            if (regReq.addr == `GENERAL_PORT_DIRECTION_ADDR) begin
                dirReg_d = regReq.wdata;
            end else if (regReq.addr == `AUX_PORT_FUNCTION_ADDR) begin
                funcReg_d = regReq.wdata;
            end else if (regReq.addr == `AUX_PORT_DATA_ADDR) begin
                auxOut_d = regReq.wdata[7:4];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        rdata_d = 8'h00;
        if (regReq.addr == `GENERAL_PORT_DATA_ADDR) begin
            rdata_d = (gpSync_q & ~hsMask) | (inReg_q & hsMask & dirReg_q);
            rdata_d = rdata_d | (gpSync_q & hsMask & ~dirReg_q);
        end else if (regReq.addr == `AUX_PORT_DATA_ADDR) begin
            rdata_d = {auxPortOut, auxSync_q};
        end else if (regReq.addr == `GENERAL_PORT_DIRECTION_ADDR) begin
            rdata_d = dirReg_q;
        end else if (regReq.addr == `AUX_PORT_FUNCTION_ADDR) begin
            rdata_d = funcReg_q;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dirReg_q <= `DIRECTION_RESET;
            funcReg_q <= `FUNCTION_RESET;
            auxOut_q <= `AUX_OUT_RESET;
            outReg_q <= 8'h00;
            inReg_q <= 8'h00;
            state_q <= byte_ports_pkg::HS_IDLE;
            hsLineOut_q <= 1'b1;
            strobePrev_q <= 1'b1;
            readyPrev_q <= 1'b1;
            hsIntRequest <= 1'b0;
            regRdata <= 8'h00;
        end else begin
            dirReg_q <= dirReg_d;
            funcReg_q <= funcReg_d;
            auxOut_q <= auxOut_d;
            outReg_q <= outReg_d;
            inReg_q <= inReg_d;
            state_q <= state_d;
            hsLineOut_q <= hsLineOut_d;
            strobePrev_q <= strobeIn;
            readyPrev_q <= readyIn;
            hsIntRequest <= intPulse_d;
            regRdata <= regReq.read ? rdata_d : 8'h00;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // pin drive
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : gpLine
            // open-drain drives only the low level
            assign generalPortOut[i] = outReg_q[i];
            assign generalPortOe[i] = !dirReg_q[i] && (funcReg_q[`FUNC_PUSH_PULL_BIT] || !outReg_q[i]);
        end
    endgenerate
    assign auxPortOut = {auxOut_q[3], hsEnable ? hsLineOut_q : auxOut_q[`HS_LINE_OUT], auxOut_q[1:0]};
    ////////////////////////////////////////////////////////////////////////
    // checks
    a_strobe_latch: assert property (@(posedge clock) disable iff (sys_rst)
        (hsEnable && hsInput && state_q == byte_ports_pkg::HS_IDLE && strobePrev_q && !strobeIn)
        |=> (!hsLineOut_q && hsIntRequest && inReg_q == $past(gpSync_q)))
        else $error("strobe did not latch");
    a_capture_protect: assert property (@(posedge clock) disable iff (sys_rst)
        (state_q == byte_ports_pkg::HS_BUSY && hsInput && hsEnable) |=> $stable(inReg_q))
        else $error("captured data overwritten");
    a_ready_return: assert property (@(posedge clock) disable iff (sys_rst)
        (hsEnable && hsInput && $past(hsEnable && hsInput) && $rose(hsLineOut_q)) |-> $past(strobeIn))
        else $error("ready rose early");
    a_write_ready: assert property (@(posedge clock) disable iff (sys_rst)
        (hsEnable && !hsInput && $past(hsEnable && !hsInput) && $fell(hsLineOut_q)) |-> $past(readyIn))
        else $error("data-available without ready");
    a_ready_fall: assert property (@(posedge clock) disable iff (sys_rst)
        (hsEnable && !hsInput && state_q == byte_ports_pkg::HS_BUSY && readyPrev_q && !readyIn)
        |=> (hsLineOut_q && hsIntRequest))
        else $error("ready fall not answered");
    a_dir_reset: assert property (@(posedge clock)
        sys_rst |=> (dirReg_q == `DIRECTION_RESET && generalPortOe == 8'h00))
        else $error("reset state wrong");
    a_open_drain: assert property (@(posedge clock) disable iff (sys_rst)
        (!funcReg_q[`FUNC_PUSH_PULL_BIT]) |-> ((generalPortOe & outReg_q) == 8'h00))
        else $error("open-drain drove high");
    a_irq_map: assert property (@(posedge clock) disable iff (sys_rst)
        intRequest[3] == auxSync_q[0] && intRequest[0] == auxSync_q[2])
        else $error("interrupt mapping wrong");
    a_out_write: assert property (@(posedge clock) disable iff (sys_rst)
        (gpWrite && !(hsEnable && !hsInput)) |=> (outReg_q == $past(regReq.wdata)))
        else $error("port write not loaded");
    a_dir_write: assert property (@(posedge clock) disable iff (sys_rst)
        (regReq.write && regReq.addr == `GENERAL_PORT_DIRECTION_ADDR) |=> (dirReg_q == $past(regReq.wdata)))
        else $error("direction write not loaded");
    a_aux_protect: assert property (@(posedge clock) disable iff (sys_rst)
        (hsEnable && $past(hsEnable) && $stable(hsLineOut_q)) |-> $stable(auxPortOut[`HS_LINE_OUT]))
        else $error("handshake line changed by write");
    a_aux_read: assert property (@(posedge clock) disable iff (sys_rst)
        (regReq.read && regReq.addr == `AUX_PORT_DATA_ADDR) |=> (regRdata == {$past(auxPortOut), $past(auxSync_q)}))
        else $error("aux read wrong");
    a_read_idle: assert property (@(posedge clock) disable iff (sys_rst)
        (!regReq.read) |=> (regRdata == 8'h00))
        else $error("read data without read");
    a_pin_read: assert property (@(posedge clock) disable iff (sys_rst)
        (regReq.read && regReq.addr == `GENERAL_PORT_DATA_ADDR && !hsEnable) |=> (regRdata == $past(gpSync_q)))
        else $error("port read not pin level");
    a_hs_read: assert property (@(posedge clock) disable iff (sys_rst)
        (regReq.read && regReq.addr == `GENERAL_PORT_DATA_ADDR && hsEnable && hsInput)
        |=> (((regRdata ^ $past(inReg_q)) & $past(hsMask & dirReg_q)) == 8'h00))
        else $error("captured value not returned");
    a_pin_sync: assert property (@(posedge clock) disable iff (sys_rst)
        (!$past(sys_rst) && !$past(sys_rst, 2)) |-> (gpSync_q == $past(generalPortIn, 2)))
        else $error("pin sampling depth wrong");
    a_pulse_once: assert property (@(posedge clock) disable iff (sys_rst)
        hsIntRequest |=> !hsIntRequest)
        else $error("request pulse too long");
    a_hold_back: assert property (@(posedge clock) disable iff (sys_rst)
        (hsEnable && !hsInput && !readyIn) |-> !fifoPop)
        else $error("data sent without ready");
endmodule
`default_nettype wire

// >>> shared/byte_ports_defines.svh
// register offsets, field positions and reset values of the byte ports
`ifndef BYTE_PORTS_DEFINES_SVH
`define BYTE_PORTS_DEFINES_SVH
`define GENERAL_PORT_DATA_ADDR 8'h02
`define AUX_PORT_DATA_ADDR 8'h03
`define GENERAL_PORT_DIRECTION_ADDR 8'hf6
`define AUX_PORT_FUNCTION_ADDR 8'hf7
`define DIRECTION_RESET 8'hff
`define FUNCTION_RESET 8'h00
`define AUX_OUT_RESET 4'hf
`define FUNC_PUSH_PULL_BIT 0
`define FUNC_HANDSHAKE_BIT 6
`define HS_LINE_IN 1
`define HS_LINE_OUT 2
`define MSB_LINE 7
`define FIFO_DEPTH 8
`endif

// >>> shared/byte_ports_pkg.sv
// types shared by the byte port block
package byte_ports_pkg;
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;
    typedef enum logic [1:0] {
        HS_IDLE,
        HS_BUSY,
        HS_WAIT
    } hs_state_type;
endpackage

// >>> rtl/byte_ports_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_ports_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] count_q, count_d;
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;
    assign inReady = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rp_q];
    always_comb begin
        wp_d = push ? AW'((wp_q + 1'b1) % DEPTH) : wp_q;
        rp_d = pop ? AW'((rp_q + 1'b1) % DEPTH) : rp_q;
        count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            count_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            count_q <= count_d;
        end
        if (push) begin
            mem[wp_q] <= inData;
        end
    end
endmodule
`default_nettype wire

// >>> tb/handshake_peripheral.sv
// far-side peripheral model for the byte port handshake
`timescale 1ns/1ps
`default_nettype none
module handshake_peripheral (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic outMode,
    input wire logic tieMode,
    input wire logic [3:0] delay,
    input wire logic strobeReq,
    input wire logic hsLineIn,
    input wire logic [7:0] portData,
    output logic hsLineOut,
    output logic latchValid,
    output logic [7:0] latchData
);
    logic lineQ;
    logic [3:0] waitQ;
    ////////////////////////////////////////
    assign hsLineOut = (tieMode && outMode) ? hsLineIn : lineQ;
    always_ff @(posedge clock) begin
        latchValid <= 1'b0;
        if (sys_rst) begin
            lineQ <= 1'b1;
            waitQ <= 4'h0;
        end else if (waitQ != 4'h0) begin
            waitQ <= waitQ - 4'h1;
        end else if (outMode) begin
            if (lineQ && !hsLineIn) begin
                lineQ <= 1'b0;
                latchValid <= 1'b1;
                latchData <= portData;
                waitQ <= delay;
            end else if (!lineQ && hsLineIn) begin
                lineQ <= 1'b1;
                waitQ <= delay;
            end
        end else if (lineQ && strobeReq) begin
            lineQ <= 1'b0;
            waitQ <= delay;
        end else if (!lineQ && (tieMode || !hsLineIn)) begin
            // strobed sender waits for the port's ready line to go low; in tieMode it ignores ready, paced by delay alone
            lineQ <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the byte port block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    byte_ports_pkg::reg_req_type regReq = '0;
    logic [7:0] regRdata, genOut, genOe, genIn, latchData, last;
    logic [7:0] ext = 8'h00;
    logic [3:0] auxDrv = 4'h0;
    logic [3:0] auxOut, irq;
    logic hsIrq, hsLine, latchValid;
    logic outMode = 1'b0;
    logic tieMode = 1'b0;
    logic strobeReq = 1'b0;
    logic rdSeen = 1'b0;
    logic [3:0] delay = 4'd1;
    logic [31:0] seed = 32'he91858fe;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    int hsCount = 0;
    int n;
    logic [7:0] expQ[$];
    logic [7:0] outQ[$];
    // pin level: our driver where enabled, else the far side
    assign genIn = (genOe & genOut) | (~genOe & ext);
    byte_ports u_dut (.clock(clock), .sys_rst(sys_rst), .regReq(regReq), .regRdata(regRdata),
        .generalPortIn(genIn), .generalPortOut(genOut), .generalPortOe(genOe),
        .auxPortIn({auxDrv[3:2], hsLine, auxDrv[0]}), .auxPortOut(auxOut), .intRequest(irq),
        .hsIntRequest(hsIrq));
    handshake_peripheral u_peer (.clock(clock), .sys_rst(sys_rst), .outMode(outMode),
        .tieMode(tieMode), .delay(delay), .strobeReq(strobeReq), .hsLineIn(auxOut[2]),
        .portData(genIn), .hsLineOut(hsLine), .latchValid(latchValid), .latchData(latchData));
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clock);
        regReq <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        @(posedge clock);
        regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clock);
        regReq <= '0;
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic strobe;
        @(posedge clock);
        strobeReq <= 1'b1;
        @(posedge clock);
        strobeReq <= 1'b0;
    endtask
    task automatic waitLine(input logic v);
        for (int k = 0; k < 60 && auxOut[2] !== v; k++) @(negedge clock);
        check({7'h0, auxOut[2]}, {7'h0, v});
    endtask
    ////////////////////////////////////////
    initial begin
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        rdSeen <= regReq.read;
        cycles <= cycles + 1;
        if (hsIrq === 1'b1) hsCount <= hsCount + 1;
        if (cycles == 20000) begin
            failures++;
            final_report;
        end
    end
    // reads answer one cycle later; latched bytes arrive in write order
    always @(negedge clock) begin
        if (rdSeen === 1'b1) check(regRdata, expQ.pop_front());
        if (latchValid === 1'b1) check(latchData, outQ.pop_front());
    end
    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        settle(0);
        check(genOe, 8'h00);
        check({4'h0, auxOut}, 8'h0f);
        rd(8'hf6, 8'hff);
        rd(8'hf7, 8'h00);
        rd(8'h55, 8'h00);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(8'hf7, {7'h00, i[2]});
            wr(8'hf6, seed[7:0]);
            wr(8'h02, seed[15:8]);
            ext <= seed[23:16];
            settle(4);
            check(genOut, seed[15:8]);
            check(genOe, ~seed[7:0] & (i[2] ? 8'hff : ~seed[15:8]));
            rd(8'h02, (seed[7:0] & seed[23:16]) | (~seed[7:0] & seed[15:8] & (i[2] ? 8'hff : seed[23:16])));
            rd(8'hf6, seed[7:0]);
        end
        wr(8'hf7, 8'h00);
        seed = lfsr(seed);
        wr(8'h03, seed[7:0]);
        auxDrv <= seed[11:8];
        settle(4);
        check({4'h0, auxOut}, {4'h0, seed[7:4]});
        check({4'h0, irq}, {4'h0, seed[8], 1'b1, seed[11], seed[10]});
        rd(8'h03, {seed[7:4], seed[11:10], 1'b1, seed[8]});
        wr(8'hf6, 8'h00);
        wr(8'h03, 8'h40);
        outMode <= 1'b1;
        delay <= 4'd6;
        wr(8'hf7, 8'h41);
        n = hsCount;
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            outQ.push_back(seed[7:0]);
            last = seed[7:0];
            wr(8'h02, seed[7:0]);
        end
        for (int k = 0; k < 400 && outQ.size() > 0; k++) @(posedge clock);
        settle(20);
        check(8'(hsCount - n), 8'd3);
        wr(8'h03, 8'h00);
        settle(4);
        check({4'h0, auxOut}, 8'h04);
        wr(8'hf7, 8'h01);
        outMode <= 1'b0;
        delay <= 4'd3;
        wr(8'hf6, 8'hff);
        wr(8'hf7, 8'h41);
        n = hsCount;
        seed = lfsr(seed);
        ext <= seed[7:0];
        strobe;
        waitLine(1'b0);
        ext <= ~seed[7:0];
        settle(20);
        check({7'h0, auxOut[2]}, 8'h00);
        check(8'(hsCount - n), 8'd1);
        rd(8'h02, seed[7:0]);
        waitLine(1'b1);
        tieMode <= 1'b1;
        wr(8'hf6, 8'h8f);
        seed = lfsr(seed);
        ext <= seed[7:0];
        strobe;
        settle(10);
        ext <= seed[15:8];
        strobe;
        settle(10);
        rd(8'h02, (seed[7:0] & 8'h8f) | (last & 8'h70));
        settle(4);
        final_report;
    end
endmodule
`default_nettype wire
